// [logic/serial_bitrate_clock_and_fifo.sv]
/*
 Bit-rate divider, clock selection and FIFO data port of one serial channel.
 Assumes every clock source input (crystal, pins, recovered clock) is
 synchronous to mclk and at most a quarter of its rate; each is used as a
 level and its rising edge taken as a count event.
*/
// Behaviour
// - Serial clock starts at idle polarity bit.
// - Divide fields choose 1x, 8x, 16x, 32x.
// - 1x fastest, 32x finest resolution.
// - All zero selects 16x oversampling.
// - Transmit internal clock: divider or recovery.
// - Receive internal clock: divider or recovery.
// - Crystal reference over 2*(N+1) times ratio.
// - System clock source divides by 2*(N+1).
// - Pin source divides by 2*(N+1).
// - Crystal reference is crystal over five.
// - Data write clears the writable flag.
// - Data read pops the receive FIFO while readable.
// - Data read clears the readable flag.
// - External timing forces 1x from pin.
// - Source field picks crystal, system clock, pins.
// - Divider runs only while enabled.
`timescale 1ns/1ps
`include "serial_bitrate_regs.svh"

module serial_bitrate_clock_and_fifo
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        crystal_in,
   input  wire logic        pin1_clk_in,
   input  wire logic        pin2_clk_in,
   input  wire logic        rx_recovered_clk,
   output logic             tx_bit_tick,
   output logic             rx_bit_tick,
   output logic             serial_clk_out,
   input  wire logic        tx_ready_set,
   output logic             tx_push_valid,
   output logic      [7:0]  tx_push_data,
   input  wire logic        rx_ready_set,
   input  wire logic [7:0]  rx_data_in,
   input  wire logic [2:0]  rx_bytes_available,
   output logic             rx_pop
);

   serial_bitrate_pkg::bitrate_config_t cfg_q;
   serial_bitrate_pkg::reg_req_t        req;
   serial_bitrate_pkg::byte_beat_t      tx_beat_q;
   logic [2:0]  xtal_div_q;
   logic        xtal_ref_q;
   logic        crystal_prev_q;
   logic        src_level;
   logic        src_prev_q;
   logic        src_edge;
   logic [10:0] div_count_q;
   logic        div_out_q;
   logic        div_prev_q;
   logic        div_edge;
   logic        rec_prev_q;
   logic        rec_edge;
   logic        pin1_prev_q;
   logic        pin2_prev_q;
   logic        tx_int_edge;
   logic        rx_int_edge;
   logic        tx_edge;
   logic        rx_edge;
   logic [4:0]  tx_ovs_top;
   logic [4:0]  rx_ovs_top;
   logic [4:0]  tx_ovs_q;
   logic [4:0]  rx_ovs_q;
   logic        tx_writable_q;
   logic        rx_readable_q;
   logic        data_wr;
   logic        data_rd;
   logic        sclk_q;
   logic        run_prev_q;

   // Bundle the register port so the decode reads as one request.
   assign req.addr  = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.wr    = reg_wr;
   assign req.rd    = reg_rd;

   assign data_wr = req.wr && (req.addr == `OFF_FIFO_DATA);
   assign data_rd = req.rd && (req.addr == `OFF_FIFO_DATA);

   // Configuration register; steers the divider, clock choice and serial clock below.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cfg_q <= `CONFIG_RESET;
      else if (req.wr && (req.addr == `OFF_BITRATE_CONFIG))
         cfg_q <= req.wdata;
   end

   // Crystal reference: one event per five rises; a toggle would halve it.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         crystal_prev_q <= 1'b0;
         xtal_div_q     <= 3'h0;
         xtal_ref_q     <= 1'b0;
      end
      else
      begin
         crystal_prev_q <= crystal_in;
         xtal_ref_q     <= 1'b0;
         if (crystal_in && !crystal_prev_q)
         begin
            if (xtal_div_q == `XTAL_PRESCALE_M1)
            begin
               xtal_div_q <= 3'h0;
               xtal_ref_q <= 1'b1;
            end
            else
               xtal_div_q <= xtal_div_q + 3'h1;
         end
      end
   end

   // Source multiplexer for the divider.
   always_comb
   begin
      unique case (cfg_q.divider_source_select)
         `SRC_CRYSTAL: src_level = xtal_ref_q;
         `SRC_SYSTEM:  src_level = 1'b1;
         `SRC_PIN1:    src_level = pin1_clk_in;
         `SRC_PIN2:    src_level = pin2_clk_in;
      endcase
   end

   // Source events: mclk counts every cycle, crystal reference is an event.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         src_prev_q <= 1'b0;
      else
         src_prev_q <= src_level;
   end

   always_comb
   begin
      unique case (cfg_q.divider_source_select)
         `SRC_CRYSTAL: src_edge = xtal_ref_q;
         `SRC_SYSTEM:  src_edge = 1'b1;
         default:      src_edge = src_level && !src_prev_q;
      endcase
   end

   // Divider: N+1 source events per half period, so 2*(N+1) per period.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_count_q <= `COUNT_ZERO;
         div_out_q   <= 1'b0;
      end
      else if (!cfg_q.divider_run)
      begin
         div_count_q <= `COUNT_ZERO;
         div_out_q   <= 1'b0;
      end
      else if (src_edge)
      begin
         if (div_count_q >= cfg_q.divisor)
         begin
            div_count_q <= `COUNT_ZERO;
            div_out_q   <= !div_out_q;
         end
         else
            div_count_q <= div_count_q + 11'h001;
      end
   end

   // Rising edges of divider output, recovered clock and pins.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_prev_q  <= 1'b0;
         rec_prev_q  <= 1'b0;
         pin1_prev_q <= 1'b0;
         pin2_prev_q <= 1'b0;
      end
      else
      begin
         div_prev_q  <= div_out_q;
         rec_prev_q  <= rx_recovered_clk;
         pin1_prev_q <= pin1_clk_in;
         pin2_prev_q <= pin2_clk_in;
      end
   end

   assign div_edge = div_out_q && !div_prev_q;
   assign rec_edge = rx_recovered_clk && !rec_prev_q;

   // Internal clock choice per direction.
   assign tx_int_edge = cfg_q.tx_internal_clock_select ? rec_edge
                                                       : div_edge;
   assign rx_int_edge = cfg_q.rx_internal_clock_select ? rec_edge
                                                       : div_edge;

   // External timing takes a pin directly: receive pin 1, transmit pin 2.
   assign tx_edge = cfg_q.tx_clock_external ?
                    (pin2_clk_in && !pin2_prev_q) : tx_int_edge;
   assign rx_edge = cfg_q.rx_clock_external ?
                    (pin1_clk_in && !pin1_prev_q) : rx_int_edge;

   // Map a divide code to its oversample count; all-zero config means 16x.
   function automatic logic [4:0] ovs_top(input logic [1:0] code,
                                          input logic       ext);
      logic [4:0] top;
      if (ext)
         top = `OVS_1X_M1;
      else if (!cfg_q.timing_mode_sel && (cfg_q.tx_clock_divide == `DIV_1X)
               && (cfg_q.rx_clock_divide == `DIV_1X))
         top = `OVS_16X_M1;
      else
         unique case (code)
            `DIV_1X:  top = `OVS_1X_M1;
            `DIV_8X:  top = `OVS_8X_M1;
            `DIV_16X: top = `OVS_16X_M1;
            `DIV_32X: top = `OVS_32X_M1;
         endcase
      return top;
   endfunction : ovs_top

   // A process, so that config fields read inside the function also wake it.
   always_comb
   begin
      tx_ovs_top = ovs_top(cfg_q.tx_clock_divide, cfg_q.tx_clock_external);
      rx_ovs_top = ovs_top(cfg_q.rx_clock_divide, cfg_q.rx_clock_external);
   end

   // Per-direction oversample counters producing one bit tick each.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_ovs_q    <= 5'h00;
         rx_ovs_q    <= 5'h00;
         tx_bit_tick <= 1'b0;
         rx_bit_tick <= 1'b0;
      end
      else
      begin
         tx_bit_tick <= 1'b0;
         rx_bit_tick <= 1'b0;
         if (tx_edge)
         begin
            if (tx_ovs_q >= tx_ovs_top)
            begin
               tx_ovs_q    <= 5'h00;
               tx_bit_tick <= 1'b1;
            end
            else
               tx_ovs_q <= tx_ovs_q + 5'h01;
         end
         if (rx_edge)
         begin
            if (rx_ovs_q >= rx_ovs_top)
            begin
               rx_ovs_q    <= 5'h00;
               rx_bit_tick <= 1'b1;
            end
            else
               rx_ovs_q <= rx_ovs_q + 5'h01;
         end
      end
   end

   // Serial clock: idle polarity until the divider starts, then toggles.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclk_q     <= 1'b0;
         run_prev_q <= 1'b0;
      end
      else
      begin
         run_prev_q <= cfg_q.divider_run;
         if (!cfg_q.divider_run || (cfg_q.divider_run && !run_prev_q))
            sclk_q <= cfg_q.clock_idle_polarity;
         else if (tx_bit_tick)
            sclk_q <= !sclk_q;
      end
   end

   assign serial_clk_out = sclk_q;

   // Transmit-ready: a set beats a same-cycle write so room is never lost.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         tx_writable_q <= 1'b0;
      else if (tx_ready_set)
         tx_writable_q <= 1'b1;
      else if (data_wr)
         tx_writable_q <= 1'b0;
   end

   // Push only while writable; a blocked write is dropped, FIFO untouched.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         tx_beat_q <= '0;
      else
      begin
         tx_beat_q.valid <= data_wr && tx_writable_q;
         if (data_wr && tx_writable_q)
            tx_beat_q.data <= req.wdata[7:0];
      end
   end

   assign tx_push_valid = tx_beat_q.valid;
   assign tx_push_data  = tx_beat_q.data;

   // Receive-ready flag: set by the channel, cleared by a data read.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rx_readable_q <= 1'b0;
      else if (rx_ready_set)
         rx_readable_q <= 1'b1;
      else if (data_rd)
         rx_readable_q <= 1'b0;
   end

   // A data read pops one entry from the receive FIFO while the readable flag is set.
   assign rx_pop = data_rd && rx_readable_q;

   // Read data stands in the cycle after the strobe and only there.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= `WORD_ZERO;
      end
      else
      begin
         reg_rdata <= `WORD_ZERO;
         if (req.rd)
            unique case (req.addr)
               `OFF_BITRATE_CONFIG: reg_rdata <= cfg_q;
               `OFF_FIFO_DATA:      reg_rdata <= {24'h000000, rx_data_in};
               `OFF_FIFO_STATUS:    reg_rdata <= {25'h0000000,
                                                  rx_bytes_available,
                                                  2'h0, tx_writable_q,
                                                  rx_readable_q};
               default:             reg_rdata <= `WORD_ZERO;
            endcase
      end
   end

endmodule : serial_bitrate_clock_and_fifo

// [logic/serial_bitrate_regs.svh]
/*
 Register offsets, field positions, reset values and timing figures for the
 serial bit-rate clock and FIFO data port.
 Assumes inclusion by bare name from any file that needs these constants.
*/
`ifndef SERIAL_BITRATE_REGS_SVH
`define SERIAL_BITRATE_REGS_SVH

// Word offsets of the registers on the plain register port.
`define OFF_BITRATE_CONFIG   4'h0
`define OFF_FIFO_DATA        4'h4
`define OFF_FIFO_STATUS      4'h8

// Fields of serial_bitrate_config.
`define F_DIVIDER_RUN        31
`define F_TIMING_MODE        30
`define F_RX_EXTERNAL        29
`define F_TX_EXTERNAL        28
`define F_SRC_HI             25
`define F_SRC_LO             24
`define F_IDLE_POL           21
`define F_TX_DIV_HI          20
`define F_TX_DIV_LO          19
`define F_RX_DIV_HI          17
`define F_RX_DIV_LO          16
`define F_TX_INT_SEL         14
`define F_RX_INT_SEL         12
`define F_N_HI               10
`define F_N_LO               0

// Divide-ratio codes.
`define DIV_1X               2'h0
`define DIV_8X               2'h1
`define DIV_16X              2'h2
`define DIV_32X              2'h3

// Oversample counts that go with each divide ratio, minus one.
`define OVS_1X_M1            5'h00
`define OVS_8X_M1            5'h07
`define OVS_16X_M1           5'h0f
`define OVS_32X_M1           5'h1f

// Source-select codes.
`define SRC_CRYSTAL          2'h0
`define SRC_SYSTEM           2'h1
`define SRC_PIN1             2'h2
`define SRC_PIN2             2'h3

// Crystal reference prescale: the reference is the crystal over five.
`define XTAL_PRESCALE_M1     3'h4

// Reset values.
`define CONFIG_RESET         32'h0000_0000
`define COUNT_ZERO           11'h000
`define BYTE_ZERO            8'h00
`define WORD_ZERO            32'h0000_0000

`endif

// [logic/serial_bitrate_pkg.sv]
/*
 Types shared by the serial bit-rate clock and FIFO data port.
 Assumes the constants header is included where numbers are needed.
*/
package serial_bitrate_pkg;

   // Software-visible configuration word, laid out as the register.
   typedef struct packed {
      logic        divider_run;
      logic        timing_mode_sel;
      logic        rx_clock_external;
      logic        tx_clock_external;
      logic [1:0]  unused_27_26;
      logic [1:0]  divider_source_select;
      logic [1:0]  unused_23_22;
      logic        clock_idle_polarity;
      logic [1:0]  tx_clock_divide;
      logic        unused_18;
      logic [1:0]  rx_clock_divide;
      logic        unused_15;
      logic        tx_internal_clock_select;
      logic        unused_13;
      logic        rx_internal_clock_select;
      logic        unused_11;
      logic [10:0] divisor;
   } bitrate_config_t;

   // Byte stream handshake towards the channel FIFOs.
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_beat_t;

   // Register port request.
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage : serial_bitrate_pkg

// [verif/serial_line_peer.sv]
/*
 Far side of the channel: clock sources and the two channel FIFOs.
 Assumes it is clocked by mclk and that every level it makes is synchronous.
*/
`timescale 1ns/1ps

module serial_line_peer
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       tx_push_valid,
   input  wire logic       rx_pop,
   output logic            crystal_in,
   output logic            pin1_clk_in,
   output logic            pin2_clk_in,
   output logic            rx_recovered_clk,
   output logic            tx_ready_set,
   output logic            rx_ready_set,
   output logic      [7:0] rx_data_in,
   output logic      [2:0] rx_bytes_available
);
   logic [7:0] rx_q [3] = '{8'h5a, 8'hc3, 8'h96};
   int         cnt;
   int         tw;
   int         rw;
   int         rc;

   // Free running sources, all at most a quarter of mclk.
   always_ff @(posedge mclk)
   begin
      cnt              <= cnt + 1;
      crystal_in       <= (cnt % 4) < 2;
      pin1_clk_in      <= (cnt % 6) < 3;
      pin2_clk_in      <= (cnt % 8) < 4;
      rx_recovered_clk <= (cnt % 10) < 5;
   end

   // Room and data come back late, so a flag stays clear for a while.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tw <= 5;
         rw <= 5;
         rc <= 3;
      end
      else
      begin
         tw <= tx_push_valid ? 20 : (tw > 0 ? tw - 1 : 0);
         rw <= (rx_pop && rc > 0) ? 20 : (rw > 0 ? rw - 1 : 0);
         if (rx_pop && rc > 0)
            rc <= rc - 1;
      end
   end

   // An empty FIFO shows a changed byte, never the last one.
   assign tx_ready_set       = (tw == 1);
   assign rx_ready_set       = (rw == 1) && (rc > 0);
   assign rx_data_in         = (rc > 0) ? rx_q[3 - rc] : ~rx_q[2];
   assign rx_bytes_available = rc[2:0];
endmodule : serial_line_peer

// [verif/serial_bitrate_clock_and_fifo_assertions.sv]
/*
 Checker for the bit-rate clock and FIFO data port, bound to its top.
 Assumes only the top module's ports are visible.
*/
`timescale 1ns/1ps
`include "serial_bitrate_regs.svh"

module serial_bitrate_clock_and_fifo_assertions
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        tx_bit_tick,
   input wire logic        serial_clk_out,
   input wire logic        tx_ready_set,
   input wire logic        tx_push_valid,
   input wire logic [7:0]  tx_push_data,
   input wire logic        rx_ready_set,
   input wire logic [7:0]  rx_data_in,
   input wire logic [2:0]  rx_bytes_available,
   input wire logic        rx_pop
);
   serial_bitrate_pkg::bitrate_config_t cfg_q;
   logic                                wflag_q;
   logic                                rflag_q;
   wire wr0 = reg_wr && reg_addr == `OFF_BITRATE_CONFIG;
   wire wr4 = reg_wr && reg_addr == `OFF_FIFO_DATA;
   wire rd4 = reg_rd && reg_addr == `OFF_FIFO_DATA;
   wire rd8 = reg_rd && reg_addr == `OFF_FIFO_STATUS;

   // Shadow of the configuration and of both flags; a set beats a clear.
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_q   <= `CONFIG_RESET;
         wflag_q <= 1'b0;
         rflag_q <= 1'b0;
      end
      else
      begin
         if (wr0)
            cfg_q <= reg_wdata;
         wflag_q <= tx_ready_set ? 1'b1 : (wr4 ? 1'b0 : wflag_q);
         rflag_q <= rx_ready_set ? 1'b1 : (rd4 ? 1'b0 : rflag_q);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_push_ok;
      wr4 && wflag_q;
   endsequence
   sequence s_push_bad;
      wr4 && !wflag_q;
   endsequence
   sequence s_idle;
      (!cfg_q.divider_run && $stable(cfg_q)) [*2];
   endsequence
   // Extra settling cycles cover a divider edge still in flight.
   sequence s_halt;
      (!cfg_q.divider_run && !cfg_q.tx_clock_external &&
       !cfg_q.tx_internal_clock_select && $stable(cfg_q)) [*4];
   endsequence

   a_idle_clock_level: assert property (
      s_idle |-> serial_clk_out == cfg_q.clock_idle_polarity)
      else $error("serial clock not at idle level");
   a_divider_halted: assert property (
      s_halt |-> !tx_bit_tick)
      else $error("tick while divider stopped");
   a_push_taken: assert property (
      s_push_ok |=> tx_push_valid && tx_push_data == $past(reg_wdata[7:0]))
      else $error("data write not pushed");
   a_push_refused: assert property (
      s_push_bad |=> !tx_push_valid)
      else $error("push while not writable");
   a_push_cause: assert property (
      tx_push_valid |-> $past(wr4))
      else $error("push without data write");
   a_pop_cause: assert property (
      rx_pop |-> rd4)
      else $error("pop without data read");
   a_data_byte: assert property (
      rd4 |=> reg_rdata[7:0] == $past(rx_data_in))
      else $error("read byte differs from head");
   a_status_flags: assert property (
      rd8 |=> reg_rdata[1] == $past(wflag_q) &&
              reg_rdata[0] == $past(rflag_q) &&
              reg_rdata[6:4] == $past(rx_bytes_available))
      else $error("status flags wrong");
endmodule : serial_bitrate_clock_and_fifo_assertions

bind serial_bitrate_clock_and_fifo serial_bitrate_clock_and_fifo_assertions
   i_chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
          .reg_rdata, .tx_bit_tick, .serial_clk_out, .tx_ready_set,
          .tx_push_valid, .tx_push_data, .rx_ready_set, .rx_data_in,
          .rx_bytes_available, .rx_pop);

// [verif/testbench.sv]
/*
 Register-level tests of the bit-rate clock and FIFO data port.
 Assumes the peer model supplies clock sources and channel FIFOs.
*/
`timescale 1ns/1ps
`include "serial_bitrate_regs.svh"

module testbench;
   logic                                mclk, rst_b, reg_wr, reg_rd;
   logic [3:0]                          reg_addr;
   logic [31:0]                         reg_wdata, reg_rdata, d;
   logic                                crystal_in, pin1_clk_in;
   logic                                pin2_clk_in, rx_recovered_clk;
   logic                                tx_bit_tick, rx_bit_tick;
   logic                                serial_clk_out, tx_ready_set;
   logic                                tx_push_valid, rx_ready_set, rx_pop;
   logic [7:0]                          tx_push_data, rx_data_in;
   logic [2:0]                          rx_bytes_available;
   serial_bitrate_pkg::bitrate_config_t c;
   int                                  miscompares = 0, compares = 0, n;
   int                                  ovs [4] = '{1, 8, 16, 32};

   serial_bitrate_clock_and_fifo i_dut (.mclk, .rst_b, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .crystal_in, .pin1_clk_in,
      .pin2_clk_in, .rx_recovered_clk, .tx_bit_tick, .rx_bit_tick,
      .serial_clk_out, .tx_ready_set, .tx_push_valid, .tx_push_data,
      .rx_ready_set, .rx_data_in, .rx_bytes_available, .rx_pop);
   serial_line_peer i_peer (.mclk, .rst_b, .tx_push_valid, .rx_pop,
      .crystal_in, .pin1_clk_in, .pin2_clk_in, .rx_recovered_clk,
      .tx_ready_set, .rx_ready_set, .rx_data_in, .rx_bytes_available);

   // Clock and a watchdog that ends a hung run.
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      repeat (30000) @(posedge mclk);
      miscompares++;
      conclude();
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // Cycles to the next tick, 3000 when none comes.
   task automatic tk(input bit rx, output int t);
      t = 0;
      do
      begin
         @(posedge mclk);
         t++;
      end
      while ((rx ? rx_bit_tick : tx_bit_tick) !== 1'b1 && t < 3000);
   endtask : tk

   // The first two spacings after a change may be partial, so skip them.
   task automatic gap(input int etx, erx);
      int t;
      repeat (3) tk(1'b0, t);
      chk("tx tick spacing", t, etx);
      repeat (3) tk(1'b1, t);
      chk("rx tick spacing", t, erx);
   endtask : gap

   // Both divide fields kept equal, timing mode set with them.
   function automatic serial_bitrate_pkg::bitrate_config_t cw(
      logic [1:0] src, logic [1:0] dv, logic [10:0] nd);
      cw = `CONFIG_RESET;
      cw.divider_run           = 1'b1;
      cw.timing_mode_sel       = 1'b1;
      cw.divider_source_select = src;
      cw.tx_clock_divide       = dv;
      cw.rx_clock_divide       = dv;
      cw.divisor               = nd;
   endfunction : cw

   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Main sequence: registers, FIFO port, then every clock path.
   initial
   begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      rd(`OFF_BITRATE_CONFIG, d);
      chk("config reset", d, `CONFIG_RESET);
      wr(4'hc, 32'hffff_ffff);
      rd(4'hc, d);
      chk("unmapped read", d, `WORD_ZERO);
      repeat (30) @(posedge mclk);
      rd(`OFF_FIFO_STATUS, d);
      chk("writable before write", d[1], 1'b1);
      wr(`OFF_FIFO_DATA, 32'h0000_00a7);
      #1 chk("push", {tx_push_valid, tx_push_data}, 9'h1a7);
      wr(`OFF_FIFO_DATA, 32'h0000_0033);
      #1 chk("blocked push", tx_push_valid, 1'b0);
      rd(`OFF_FIFO_STATUS, d);
      chk("status before read", d[6:0], 7'h31);
      rd(`OFF_FIFO_DATA, d);
      chk("rx byte", d[7:0], 8'h5a);
      rd(`OFF_FIFO_STATUS, d);
      chk("status after read", d[6:0], 7'h20);
      c = cw(`SRC_SYSTEM, `DIV_1X, 11'h001);
      c.divider_run = 1'b0;
      c.clock_idle_polarity = 1'b1;
      wr(`OFF_BITRATE_CONFIG, c);
      tk(1'b0, n);
      chk("stopped divider", n, 3000);
      chk("idle high", serial_clk_out, 1'b1);
      c.clock_idle_polarity = 1'b0;
      wr(`OFF_BITRATE_CONFIG, c);
      repeat (3) @(posedge mclk);
      chk("idle low", serial_clk_out, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         wr(`OFF_BITRATE_CONFIG, cw(`SRC_SYSTEM, i[1:0], 11'h001));
         gap(4 * ovs[i], 4 * ovs[i]);
      end
      c = cw(`SRC_SYSTEM, `DIV_1X, 11'h001);
      c.timing_mode_sel = 1'b0;
      wr(`OFF_BITRATE_CONFIG, c);
      gap(64, 64);
      wr(`OFF_BITRATE_CONFIG, cw(`SRC_CRYSTAL, `DIV_1X, 11'h000));
      gap(40, 40);
      wr(`OFF_BITRATE_CONFIG, cw(`SRC_CRYSTAL, `DIV_16X, 11'h000));
      gap(640, 640);
      wr(`OFF_BITRATE_CONFIG, cw(`SRC_PIN1, `DIV_1X, 11'h002));
      gap(36, 36);
      wr(`OFF_BITRATE_CONFIG, cw(`SRC_PIN2, `DIV_1X, 11'h000));
      gap(16, 16);
      c = cw(`SRC_SYSTEM, `DIV_1X, 11'h001);
      c.tx_internal_clock_select = 1'b1;
      wr(`OFF_BITRATE_CONFIG, c);
      gap(10, 4);
      c.tx_internal_clock_select = 1'b0;
      c.rx_internal_clock_select = 1'b1;
      wr(`OFF_BITRATE_CONFIG, c);
      gap(4, 10);
      c = cw(`SRC_SYSTEM, `DIV_32X, 11'h001);
      c.tx_clock_external = 1'b1;
      c.rx_clock_external = 1'b1;
      wr(`OFF_BITRATE_CONFIG, c);
      gap(8, 6);
      conclude();
   end
endmodule : testbench
